// ---- doc_host_model.sv ----
// Serial bus master model for the converter control link
`timescale 1ns/100ps
`default_nettype none
module doc_host_model
(
    // Link pins
    output logic sclk_o,
    output logic cs_n_o,
    output logic sdi_o,
    input wire logic sdo_i,
    // Readback
    output logic [23:0] rd_o,
    output logic rd_tgl_o
);
    // No alarm input: its level is never acted on
    initial
    begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        sdi_o = 1'b0;
        rd_o = 24'h000000;
        rd_tgl_o = 1'b0;
    end
    // One 24-bit frame at 8 MHz, MSB first, clock idle low
    task automatic frame(input logic [23:0] w);
        #1 cs_n_o = 1'b0;
        for (int i = 23; i >= 0; i--)
        begin
            #20.5 sdi_o = w[i];
            #34.5 rd_o = {rd_o[22:0], sdi_i_unused(sdo_i)};
            #7.5 sclk_o = 1'b1;
            #62.5 sclk_o = 1'b0;
        end
        #62.5 cs_n_o = 1'b1;
        sdi_o = ~sdi_o;
        rd_tgl_o = ~rd_tgl_o;
        #250;
    endtask
    // Passes the sampled line through unchanged
    function automatic logic sdi_i_unused(input logic b);
        return b;
    endfunction
endmodule
`default_nettype wire

// ---- doc_link_if.sv ----
// Interface carrying decoded link events between the two modules
`timescale 1ns/100ps
`default_nettype none
interface doc_link_if;
    logic frame_end;
    logic [23:0] word;
    logic [23:0] load_word;
    logic load;
    modport front (output frame_end, output word, input load_word, input load);
    modport core (input frame_end, input word, output load_word, output load);
endinterface
`default_nettype wire

// ---- doc_output_ctrl.sv ----
// Top of the converter output control logic
`timescale 1ns/100ps
`default_nettype none
module doc_output_ctrl
(
    // Clock, reset, enable
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic ce_i,
    // Serial link
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic sdi_i,
    output logic sdo_o,
    output logic sdo_oe_o,
    // Asynchronous pins
    input wire logic load_converter_n_i,
    input wire logic clear_in_n_i,
    // Analog status
    input wire logic current_open_i,
    input wire logic voltage_short_i,
    // Alarm, open drain
    output logic alarm_o,
    output logic alarm_oe_o,
    // Converter state
    output logic [15:0] conv_code_o,
    output logic voltage_output_o,
    output logic current_output_o,
    output logic unipolar_o,
    output logic range_4ma_o
);
    // ************************************************
    // Pin synchronisers
    // ************************************************
    logic [1:0] ld_q;
    logic [1:0] clr_q;
    logic [1:0] open_q;
    logic [1:0] short_q;
    logic [15:0] ctl_q;
    logic [15:0] in_q;
    logic [15:0] conv_q;
    logic [15:0] clrv_q;
    logic [23:0] ld_word_q;
    logic ld_now_q;
    doc_link_if lnk ();

    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            ld_q <= 2'h3;
            clr_q <= 2'h3;
            open_q <= 2'h0;
            short_q <= 2'h0;
        end
        else if (ce_i)
        begin
            ld_q <= {ld_q[0], load_converter_n_i};
            clr_q <= {clr_q[0], clear_in_n_i};
            open_q <= {open_q[0], current_open_i};
            short_q <= {short_q[0], voltage_short_i};
        end
    end

    doc_serial_link u_link
    (
        .clk_sys_i(clk_sys_i),
        .srst_i(srst_i),
        .ce_i(ce_i),
        .sclk_i(sclk_i),
        .cs_n_i(cs_n_i),
        .sdi_i(sdi_i),
        .sdo_o(sdo_o),
        .sdo_oe_o(sdo_oe_o),
        .lnk(lnk.front)
    );

    // ************************************************
    // Command decode
    // ************************************************
    wire [3:0] cmd = lnk.word[19:16];
    wire [15:0] dat = lnk.word[15:0];
    wire fe = lnk.frame_end;
    wire fault_act = open_q[1] | short_q[1];
    wire clear_pin_enable = ctl_q[doc_pkg::CTL_CLR_PIN_EN];
    wire clear_act = ~clr_q[1] & clear_pin_enable;
    wire load_act = ~ld_q[1];
    wire wr_ctl = fe && cmd == doc_pkg::CMD_WR_CTRL;
    wire wr_in = fe && (cmd == doc_pkg::CMD_LD_INPUT ||
        cmd == doc_pkg::CMD_LD_BOTH);
    wire wr_both = fe && cmd == doc_pkg::CMD_LD_BOTH;
    wire wr_xfer = fe && cmd == doc_pkg::CMD_LD_CONV;
    wire wr_clr = fe && cmd == doc_pkg::CMD_WR_CLEAR;
    wire [15:0] zero_code = (ctl_q[doc_pkg::CTL_UNIPOLAR] |
        ctl_q[doc_pkg::CTL_CURR_EN]) ? doc_pkg::ZERO_UNI : doc_pkg::ZERO_BIP;
    wire [15:0] clear_code = ctl_q[doc_pkg::CTL_SOFT_CLR] ? clrv_q :
        zero_code;
    wire [15:0] ctl_new = dat & doc_pkg::CTL_WR_MASK;
    wire ctl_bad = ctl_new[doc_pkg::CTL_VOLT_EN] &
        ctl_new[doc_pkg::CTL_CURR_EN];
    wire [15:0] ctl_rd = {ctl_q[15:5], 2'h0, fault_act, 2'h0};
    wire rd_sel = fe && (cmd == doc_pkg::CMD_RD_CTRL ||
        cmd == doc_pkg::CMD_RD_INPUT || cmd == doc_pkg::CMD_RD_CONV ||
        cmd == doc_pkg::CMD_RD_CLEAR);
    wire [15:0] rd_data = (cmd == doc_pkg::CMD_RD_CTRL) ? ctl_rd :
        (cmd == doc_pkg::CMD_RD_INPUT) ? in_q :
        (cmd == doc_pkg::CMD_RD_CONV) ? conv_q : clrv_q;

    // ************************************************
    // Registers
    // ************************************************
    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            ctl_q <= doc_pkg::RST_REG;
            in_q <= doc_pkg::RST_REG;
            conv_q <= doc_pkg::RST_REG;
            clrv_q <= doc_pkg::RST_REG;
            ld_word_q <= 24'h000000;
            ld_now_q <= 1'b0;
        end
        else if (ce_i)
        begin
            ld_now_q <= rd_sel;
            ld_word_q <= {lnk.word[23:16], rd_data};
            if (wr_ctl && !ctl_bad)
                ctl_q <= ctl_new;
            if (wr_in)
                in_q <= dat;
            if (wr_clr)
                clrv_q <= dat;
            if (clear_act)
                conv_q <= clear_code;
            else if (wr_both)
                conv_q <= dat;
            else if (wr_xfer || load_act)
                conv_q <= in_q;
        end
    end

    assign lnk.load = ld_now_q;
    assign lnk.load_word = ld_word_q;
    assign conv_code_o = conv_q;
    assign voltage_output_o = ctl_q[doc_pkg::CTL_VOLT_EN];
    assign current_output_o = ctl_q[doc_pkg::CTL_CURR_EN];
    assign unipolar_o = ctl_q[doc_pkg::CTL_UNIPOLAR];
    assign range_4ma_o = ctl_q[doc_pkg::CTL_RANGE_4MA];
    assign alarm_o = 1'b0;
    assign alarm_oe_o = fault_act | ~clr_q[1];

    // ************************************************
    // Checks
    // ************************************************
    chk_one_output_only: assert property (@(posedge clk_sys_i) disable iff
        (srst_i) !(voltage_output_o && current_output_o))
        else $error("both outputs enabled");
    chk_alarm_on_clear: assert property (@(posedge clk_sys_i) disable iff
        (srst_i) ce_i && !clear_in_n_i |=> ##1 alarm_oe_o)
        else $error("alarm not driven during clear");
    chk_clear_code: assert property (@(posedge clk_sys_i) disable iff
        (srst_i) ce_i && clear_act |=> conv_q == $past(clear_code))
        else $error("clear code not applied");
    chk_clear_gated: assert property (@(posedge clk_sys_i) disable iff
        (srst_i) ce_i && !clear_pin_enable && !load_act && !fe
        |=> $stable(conv_q))
        else $error("converter changed while idle");
    chk_load_pin: assert property (@(posedge clk_sys_i) disable iff
        (srst_i) ce_i && load_act && !clear_act && !fe
        |=> conv_q == $past(in_q))
        else $error("load pin transfer missed");
    chk_clear_reg_write: assert property (@(posedge clk_sys_i) disable iff
        (srst_i) ce_i && wr_clr |=> clrv_q == $past(dat))
        else $error("clear register not written");
    chk_reset_off: assert property (@(posedge clk_sys_i)
        srst_i |=> !voltage_output_o && !current_output_o
        && conv_q == 16'h0000)
        else $error("outputs not off after reset");
    chk_input_stage: assert property (@(posedge clk_sys_i) disable iff
        (srst_i) ce_i && wr_in && !wr_both && !clear_act && !load_act
        |=> in_q == $past(dat) && $stable(conv_q))
        else $error("input staging disturbed converter");
    chk_cmd_transfer: assert property
        (@(posedge clk_sys_i) disable iff (srst_i)
        ce_i && wr_xfer && !clear_act |=> conv_q == $past(in_q))
        else $error("input not moved by command");
    chk_both_load: assert property
        (@(posedge clk_sys_i) disable iff (srst_i)
        ce_i && wr_both && !clear_act
        |=> conv_q == $past(dat) && in_q == $past(dat))
        else $error("direct load missed a register");
    chk_alarm_fault: assert property
        (@(posedge clk_sys_i) disable iff (srst_i)
        !srst_i && ce_i && (current_open_i || voltage_short_i)
        ##1 ce_i |=> alarm_oe_o)
        else $error("alarm not driven on fault");
    chk_cleared_hold: assert property
        (@(posedge clk_sys_i) disable iff (srst_i)
        ce_i && !clear_act && !load_act && !fe |=> $stable(conv_q))
        else $error("converter moved without update");
    cov_clear: cover property (@(posedge clk_sys_i) clear_act);
    cov_load: cover property (@(posedge clk_sys_i) load_act);
    cov_xfer: cover property (@(posedge clk_sys_i) wr_xfer);
    cov_read: cover property (@(posedge clk_sys_i) ld_now_q);
endmodule
`default_nettype wire

// ---- doc_output_ctrl_tb.sv ----
// Self-checking bench for the converter output control logic
`timescale 1ns/100ps
`default_nettype none
module doc_output_ctrl_tb;
    logic clk_sys_i, srst_i, sclk, cs_n, sdi, sdo, sdo_oe, sdo_last, sdo_w;
    logic load_n, clr_n, cur_open, volt_short, alarm, alarm_oe;
    logic volt_en, curr_en, unip, rng4, rd_tgl, rd_last;
    logic [3:0] up;
    logic [15:0] code, rnd;
    logic [19:0] stat, stat_last, exp_s;
    logic [23:0] rd, exp_r;
    logic [19:0] stat_q[$];
    logic [23:0] rd_q[$];
    int fail_count, tests_run;
    doc_output_ctrl DUT (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .ce_i(1'b1),
        .sclk_i(sclk), .cs_n_i(cs_n), .sdi_i(sdi), .sdo_o(sdo),
        .sdo_oe_o(sdo_oe), .load_converter_n_i(load_n), .clear_in_n_i(clr_n),
        .current_open_i(cur_open), .voltage_short_i(volt_short),
        .alarm_o(alarm), .alarm_oe_o(alarm_oe), .conv_code_o(code),
        .voltage_output_o(volt_en), .current_output_o(curr_en),
        .unipolar_o(unip), .range_4ma_o(rng4));
    doc_host_model host (.sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(sdi),
        .sdo_i(sdo_w), .rd_o(rd), .rd_tgl_o(rd_tgl));
    // Released line shows the inverse of its last driven level
    assign sdo_w = sdo_oe ? sdo : ~sdo_last;
    assign stat = {volt_en, curr_en, unip, rng4, code};
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test;
        $display("Checks %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        host.frame({c, d});
        check(sdo_oe, 1'b0);
    endtask
    task automatic pins(input logic ld, input logic cl);
        @(posedge clk_sys_i);
        load_n <= ld;
        clr_n <= cl;
        repeat (10) @(posedge clk_sys_i);
        check(alarm_oe, !cl);
        load_n <= 1'b1;
        clr_n <= 1'b1;
        repeat (10) @(posedge clk_sys_i);
        check(alarm_oe, 1'b0);
    endtask
    initial
    begin
        clk_sys_i = 1'b0;
        forever #4 clk_sys_i = ~clk_sys_i;
    end
    initial
    begin
        #400000;
        fail_count++;
        finish_test();
    end
    // Output watchers
    always @(posedge clk_sys_i)
    begin
        stat_last <= stat;
        rd_last <= rd_tgl;
        if (sdo_oe)
            sdo_last <= sdo;
        if (!srst_i && stat !== stat_last)
        begin
            exp_s = stat_q.size() ? stat_q.pop_front() : ~stat;
            check(stat, exp_s);
        end
        if (rd_tgl !== rd_last && rd_q.size() > 0)
        begin
            exp_r = rd_q.pop_front();
            check(rd[22:0], exp_r[22:0]);
        end
    end
    always @(sdo)
        if (sdo_oe === 1'b1)
            check(sclk, 1'b0);
    initial
    begin
        srst_i = 1'b1;
        load_n = 1'b1;
        clr_n = 1'b1;
        cur_open = 1'b0;
        volt_short = 1'b0;
        sdo_last = 1'b0;
        stat_last = 20'h00000;
        rd_last = 1'b0;
        fail_count = 0;
        tests_run = 0;
        void'($urandom(32'h85049a69));
        up = 4'($urandom_range(15, 0));
        rnd = {1'b1, 15'($urandom_range(32767, 0))};
        repeat (6) @(posedge clk_sys_i);
        srst_i <= 1'b0;
        @(posedge clk_sys_i);
        check(stat, 20'h00000);
        check({alarm_oe, sdo_oe, alarm}, 24'h000000);
        stat_q.push_back({4'ha, 16'h0000});
        wr({up, doc_pkg::CMD_WR_CTRL}, 16'h9600);
        wr({up, doc_pkg::CMD_WR_CTRL}, 16'hc000);
        wr({up, doc_pkg::CMD_LD_INPUT}, 16'h1234);
        stat_q.push_back({4'ha, 16'h1234});
        wr({up, doc_pkg::CMD_LD_CONV}, 16'h0000);
        wr({up, doc_pkg::CMD_LD_INPUT}, rnd);
        stat_q.push_back({4'ha, rnd});
        pins(1'b0, 1'b1);
        wr({up, doc_pkg::CMD_WR_CLEAR}, 16'h0abc);
        stat_q.push_back({4'ha, 16'h0abc});
        pins(1'b1, 1'b0);
        wr({up, doc_pkg::CMD_WR_CTRL}, 16'h9400);
        pins(1'b1, 1'b0);
        stat_q.push_back({4'h8, 16'h0abc});
        wr({up, doc_pkg::CMD_WR_CTRL}, 16'h8200);
        stat_q.push_back({4'h8, 16'h8000});
        pins(1'b1, 1'b0);
        wr({4'h0, doc_pkg::CMD_RD_CONV}, 16'h0000);
        rd_q.push_back({4'h0, doc_pkg::CMD_RD_CONV, 16'h8000});
        wr({4'h0, doc_pkg::CMD_RD_CLEAR}, 16'h0000);
        rd_q.push_back({4'h0, doc_pkg::CMD_RD_CLEAR, 16'h0abc});
        wr({4'h0, doc_pkg::CMD_RD_INPUT}, 16'h0000);
        rd_q.push_back({4'h0, doc_pkg::CMD_RD_INPUT, rnd});
        wr({4'h0, doc_pkg::CMD_NOP}, 16'h0000);
        stat_q.push_back({4'h5, 16'h8000});
        wr({up, doc_pkg::CMD_WR_CTRL}, 16'h4800);
        stat_q.push_back({4'h5, 16'h5a5a});
        wr({up, doc_pkg::CMD_LD_BOTH}, 16'h5a5a);
        wr({4'h0, doc_pkg::CMD_RD_CTRL}, 16'h0000);
        rd_q.push_back({4'h0, doc_pkg::CMD_RD_CTRL, 16'h4800});
        wr({4'h0, doc_pkg::CMD_NOP2}, 16'h0000);
        for (int i = 0; i < 4; i++)
        begin
            @(posedge clk_sys_i);
            cur_open <= i[0];
            volt_short <= i[1];
            repeat (6) @(posedge clk_sys_i);
            check(alarm_oe, i != 0);
        end
        srst_i <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        srst_i <= 1'b0;
        @(posedge clk_sys_i);
        check(stat, 20'h00000);
        check(24'(stat_q.size() + rd_q.size()), 24'h000000);
        finish_test();
    end
endmodule
`default_nettype wire

// ---- doc_pkg.sv ----
// Constants for the converter output control logic
package doc_pkg;
    localparam int unsigned WORD_BITS = 24;
    localparam int unsigned CODE_BITS = 16;
    localparam logic [3:0] CMD_NOP = 4'h0;
    localparam logic [3:0] CMD_WR_CTRL = 4'h1;
    localparam logic [3:0] CMD_RD_CTRL = 4'h2;
    localparam logic [3:0] CMD_LD_INPUT = 4'h3;
    localparam logic [3:0] CMD_LD_BOTH = 4'h4;
    localparam logic [3:0] CMD_LD_CONV = 4'h5;
    localparam logic [3:0] CMD_WR_CLEAR = 4'h6;
    localparam logic [3:0] CMD_RD_INPUT = 4'h7;
    localparam logic [3:0] CMD_RD_CONV = 4'h8;
    localparam logic [3:0] CMD_RD_CLEAR = 4'h9;
    localparam logic [3:0] CMD_NOP2 = 4'hf;
    // Control register field positions
    localparam int unsigned CTL_VOLT_EN = 15;
    localparam int unsigned CTL_CURR_EN = 14;
    localparam int unsigned CTL_UNIPOLAR = 12;
    localparam int unsigned CTL_RANGE_4MA = 11;
    localparam int unsigned CTL_SOFT_CLR = 10;
    localparam int unsigned CTL_CLR_PIN_EN = 9;
    localparam logic [15:0] CTL_WR_MASK = 16'hdfe0;
    localparam logic [15:0] RST_REG = 16'h0000;
    localparam logic [15:0] ZERO_UNI = 16'h0000;
    localparam logic [15:0] ZERO_BIP = 16'h8000;
    localparam logic [4:0] CNT_RST = 5'h00;
    localparam logic [4:0] CNT_LAST = 5'h17;
endpackage

// ---- doc_serial_link.sv ----
// Serial link front end: sync, edge detect, shift register, readback
`timescale 1ns/100ps
`default_nettype none
module doc_serial_link
(
    // Clock, reset, enable
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic ce_i,
    // Link pins
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic sdi_i,
    output logic sdo_o,
    output logic sdo_oe_o,
    // Toward core
    doc_link_if.front lnk
);
    logic [2:0] sclk_q;
    logic [2:0] cs_q;
    logic [1:0] sdi_q;
    logic [23:0] shift_q;
    logic sdo_q;
    logic frame_q;
    wire sclk_rise = sclk_q[1] & ~sclk_q[2];
    wire sclk_fall = ~sclk_q[1] & sclk_q[2];
    wire cs_low = ~cs_q[1];
    wire cs_rise = cs_q[1] & ~cs_q[2];

    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            sclk_q <= 3'h0;
            cs_q <= 3'h7;
            sdi_q <= 2'h0;
        end
        else if (ce_i)
        begin
            sclk_q <= {sclk_q[1:0], sclk_i};
            cs_q <= {cs_q[1:0], cs_n_i};
            sdi_q <= {sdi_q[0], sdi_i};
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            shift_q <= 24'h000000;
            sdo_q <= 1'b0;
            frame_q <= 1'b0;
        end
        else if (ce_i)
        begin
            frame_q <= cs_rise;
            if (lnk.load)
                shift_q <= lnk.load_word;
            else if (cs_low && sclk_rise)
                shift_q <= {shift_q[22:0], sdi_q[1]};
            if (cs_low && sclk_fall)
                sdo_q <= shift_q[23];
        end
    end

    assign sdo_o = sdo_q;
    assign sdo_oe_o = cs_low;
    assign lnk.frame_end = frame_q;
    assign lnk.word = shift_q;

    chk_dout_falling_edge: assert property (@(posedge clk_sys_i) disable iff
        (srst_i) !$stable(sdo_q) |-> $past(sclk_fall))
        else $error("sdo changed without sclk fall");
    chk_dout_hiz: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        ce_i && cs_n_i ##1 ce_i |=> !sdo_oe_o)
        else $error("sdo driven while deselected");
    chk_dout_source: assert property
        (@(posedge clk_sys_i) disable iff (srst_i)
        ce_i && cs_low && sclk_fall |=> sdo_q == $past(shift_q[23]))
        else $error("sdo not from shift register");
    chk_shift_sample: assert property (@(posedge clk_sys_i) disable iff
        (srst_i) ce_i && cs_low && sclk_rise && !lnk.load
        |=> shift_q[0] == $past(sdi_q[1]))
        else $error("sdi bit not shifted in");
    chk_idle_hold: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        cs_q[1] && !lnk.load |=> $stable(shift_q))
        else $error("shift moved while deselected");
    cov_frame: cover property (@(posedge clk_sys_i) cs_rise);
endmodule
`default_nettype wire
